// ===== inc/angle_trim_pkg.sv
package angle_trim_pkg;

  // Register byte offsets on the APB bus.
  localparam logic [11:0] CTRL_OFS = 12'h000;
  localparam logic [11:0] ZERO_OFS = 12'h004;
  localparam logic [11:0] LIMIT_OFS = 12'h008;
  localparam logic [11:0] GAIN_OFS = 12'h00c;
  localparam logic [11:0] STATUS_OFS = 12'h010;
  localparam logic [11:0] ANGLE_OFS = 12'h014;
  // Channel blocks start at 0x20 and 0x40; values below are word indices within a block.
  localparam logic [2:0] CH_SCALE_IDX = 3'h0;
  localparam logic [2:0] CH_SCALE_TC_IDX = 3'h1;
  localparam logic [2:0] CH_SQUARE_TC_IDX = 3'h2;
  localparam logic [2:0] CH_SHIFT_IDX = 3'h3;
  localparam logic [2:0] CH_SHIFT_TC_IDX = 3'h4;
  localparam logic [2:0] CH_DEADBAND_IDX = 3'h5;
  localparam logic [2:0] CH_READBACK_IDX = 3'h6;

  // Control register bit positions.
  localparam int FIRST_INVERT_BIT = 0;
  localparam int SECOND_INVERT_BIT = 1;
  localparam int SKIP_BIT = 2;
  localparam int SWAP_BIT = 3;
  localparam int DIR_INVERT_BIT = 4;
  localparam int LIMIT_ON_BIT = 5;
  localparam int CLAMP_ON_BIT = 6;
  // Field positions shared by the split registers.
  localparam int HOT_POS = 16;
  localparam int UPPER_POS = 8;
  localparam int WRAP_POS = 16;

  // Reset values.
  localparam logic [6:0] CTRL_RST = 7'h40;
  localparam logic [14:0] SCALE_RST = 15'h0800;
  localparam logic [15:0] GAIN_RST = 16'h0400;

  // Numeric constants of the datapath.
  localparam logic signed [16:0] TEMP_REF_CODE = 17'sh000c8;
  localparam logic [15:0] ANGLE_BIAS = 16'h8000;
  localparam logic [15:0] ANGLE_QUARTER = 16'h4000;
  localparam logic [15:0] ANGLE_HALF = 16'h8000;
  localparam logic [15:0] ANGLE_3QUARTER = 16'hc000;
  localparam logic [15:0] ANGLE_MAX = 16'hffff;
  localparam logic [3:0] CORDIC_LAST = 4'hf;

  typedef enum logic [2:0] {
    PH_IDLE = 3'b000,
    PH_TRIM = 3'b001,
    PH_ANGLE = 3'b010,
    PH_CORDIC = 3'b011,
    PH_POST = 3'b100
  } phase_t;

  typedef struct packed {
    logic signed [15:0] first;
    logic signed [15:0] second;
    logic signed [15:0] temp;
  } sample_t;

  typedef struct packed {
    logic [14:0] scale;
    logic signed [10:0] lin_cold;
    logic signed [10:0] lin_hot;
    logic signed [9:0] sq_cold;
    logic signed [9:0] sq_hot;
    logic signed [13:0] shift;
    logic signed [11:0] shift_cold;
    logic signed [11:0] shift_hot;
    logic [9:0] deadband;
  } chan_cfg_t;

  typedef struct packed {
    logic signed [15:0] out;
    logic signed [15:0] head;
    logic primed;
    logic dir_known;
    logic dir_up;
  } hyst_t;

  function automatic logic [15:0] atan_step(input logic [3:0] i);
    unique case (i)
      4'h0: atan_step = 16'h2000;
      4'h1: atan_step = 16'h12e4;
      4'h2: atan_step = 16'h09fb;
      4'h3: atan_step = 16'h0511;
      4'h4: atan_step = 16'h028b;
      4'h5: atan_step = 16'h0146;
      4'h6: atan_step = 16'h00a3;
      4'h7: atan_step = 16'h0051;
      4'h8: atan_step = 16'h0029;
      4'h9: atan_step = 16'h0014;
      4'ha: atan_step = 16'h000a;
      4'hb: atan_step = 16'h0005;
      4'hc: atan_step = 16'h0003;
      4'hd: atan_step = 16'h0001;
      4'he: atan_step = 16'h0001;
      4'hf: atan_step = 16'h0000;
    endcase
  endfunction

endpackage

// ===== rtl/angle_trim_signal_path.sv
// Contract
// - Polarity bit negates each channel, first step before scaling and offsets.
// - Channel times unsigned scale coefficient, step 2^-11, reset 2048 is unity.
// - Scaled channel times one plus linear and square tempco terms, cold/hot sets.
// - Tempco steps 2^-17, 2^-18 linear and 2^-25, 2^-23 square, signed.
// - Signed channel shift added, -32768 to +32764 in steps of four.
// - Shift tempco times temperature delta added; cold step 1/8, hot 1/16.
// - Hysteresis deadband 0 to 1023 counts; zero disables the filter.
// - Input moving in reference direction sits at window head, no added latency.
// - On reversal hold output until window exit; opposite exit flips head, direction.
// - First input change after reset sets the initial reference direction.
// - Both filtered channel values readable as 16-bit words.
// - Without skip, angle is iterative arctangent; swap bit picks sine channel.
// - With skip, angle is selected channel plus 32768.
// - Arctangent gives exact 0, 90, 180 and 270 on the axes.
// - Direction invert bit replaces angle by 360 minus angle.
// - Zero point shift added modulo 360, always wrapping.
// - Limit check flags out-of-range angle, never clamps it.
// - Angle times unsigned gain, step 2^-10; zero gain gives zero.
// - Without clamp the gained angle wraps modulo 360.
// - With clamp: gained below 360, then full scale to wrap point, then zero.
`timescale 1ns/100ps
module angle_trim_signal_path (
  input wire logic pclk,
  input wire logic presetn,
  input wire logic ce,
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [11:0] paddr,
  input wire logic [31:0] pwdata,
  output logic [31:0] prdata,
  output logic pready,
  output logic pslverr,
  input wire logic sample_valid,
  input wire angle_trim_pkg::sample_t sample_in,
  output logic sample_ready,
  output logic [15:0] angle_out,
  output logic angle_valid,
  output logic sat_flag
);

  typedef struct packed {
    angle_trim_pkg::phase_t phase;
    angle_trim_pkg::sample_t smp;
    logic [6:0] ctrl;
    logic [14:0] zero_shift;
    logic [7:0] limit_lower;
    logic [7:0] limit_upper;
    logic [7:0] wrap_point;
    logic [15:0] scale_factor;
    angle_trim_pkg::chan_cfg_t [1:0] cfg;
    angle_trim_pkg::hyst_t [1:0] hyst;
    logic signed [19:0] cx;
    logic signed [19:0] cy;
    logic [15:0] cz;
    logic [3:0] iter;
    logic [15:0] angle;
    logic angle_valid;
    logic sat;
    logic ready;
    logic pready;
    logic pslverr;
    logic [31:0] prdata;
  } state_t;

  state_t st_r;
  state_t st_nxt;
  angle_trim_pkg::hyst_t [1:0] hyst_upd;
  logic signed [16:0] dt8;
  logic cold;

  // Temperature delta to 25 degrees in eighths of a kelvin.
  assign dt8 = 17'(st_r.smp.temp) - angle_trim_pkg::TEMP_REF_CODE;
  assign cold = dt8[16];

  for (genvar c = 0; c < 2; c++)
  begin : g_chan
    logic signed [15:0] raw;
    logic signed [16:0] inv;
    logic signed [32:0] s4;
    logic signed [33:0] dt2;
    logic signed [47:0] f28;
    logic signed [63:0] s5;
    logic signed [63:0] s7;
    logic signed [15:0] trim;
    logic signed [16:0] w;
    angle_trim_pkg::hyst_t h;
    angle_trim_pkg::hyst_t hn;

    assign raw = (c == 0) ? st_r.smp.first : st_r.smp.second;
    assign inv = st_r.ctrl[c] ? -17'(raw) : 17'(raw);
    assign s4 = (33'(inv) * $signed({18'h0, st_r.cfg[c].scale})) >>> 11;
    assign dt2 = 34'(dt8) * 34'(dt8);
    always_comb
    begin
      f28 = 48'sh0000_1000_0000;
      if (cold)
      begin
        f28 = f28 + ((48'(st_r.cfg[c].lin_cold) * 48'(dt8)) <<< 8);
        f28 = f28 + ((48'(st_r.cfg[c].sq_cold) * 48'(dt2)) >>> 3);
      end
      else
      begin
        f28 = f28 + ((48'(st_r.cfg[c].lin_hot) * 48'(dt8)) <<< 7);
        f28 = f28 + ((48'(st_r.cfg[c].sq_hot) * 48'(dt2)) >>> 1);
      end
    end
    assign s5 = (64'(s4) * 64'(f28)) >>> 28;
    always_comb
    begin
      s7 = s5 + (64'(st_r.cfg[c].shift) <<< 2);
      if (cold)
        s7 = s7 + ((64'(st_r.cfg[c].shift_cold) * 64'(dt8)) >>> 6);
      else
        s7 = s7 + ((64'(st_r.cfg[c].shift_hot) * 64'(dt8)) >>> 7);
      if (s7 > 64'sd32767)
        trim = 16'sh7fff;
      else if (s7 < -64'sd32768)
        trim = 16'sh8000;
      else
        trim = s7[15:0];
    end

    // Hysteresis: the head tracks the input while it advances.
    assign w = $signed({7'h0, st_r.cfg[c].deadband});
    assign h = st_r.hyst[c];
    always_comb
    begin
      hn = h;
      if (w == 17'sd0)
      begin
        hn.out = trim;
        hn.head = trim;
        hn.primed = 1'b1;
        hn.dir_known = 1'b0;
      end
      else if (!h.primed)
      begin
        hn.out = trim;
        hn.head = trim;
        hn.primed = 1'b1;
      end
      else if (!h.dir_known)
      begin
        if (trim != h.head)
        begin
          hn.dir_known = 1'b1;
          hn.dir_up = trim > h.head;
          hn.out = trim;
          hn.head = trim;
        end
      end
      else if (h.dir_up ? (trim >= h.head) : (trim <= h.head))
      begin
        hn.out = trim;
        hn.head = trim;
      end
      else if (h.dir_up ? (17'(trim) < 17'(h.head) - w) : (17'(trim) > 17'(h.head) + w))
      begin
        hn.dir_up = !h.dir_up;
        hn.head = trim;
        hn.out = trim;
      end
    end
    assign hyst_upd[c] = hn;
  end

  logic access;
  logic is_chan;
  logic ch;
  logic mapped;
  logic [31:0] rd;
  logic signed [15:0] sine;
  logic signed [15:0] cosine;
  logic [15:0] a1;
  logic [15:0] a2;
  logic [31:0] prod;
  logic [21:0] gained;
  logic [15:0] a3;
  logic limit_hit;

  always_comb
  begin
    st_nxt = st_r;
    st_nxt.angle_valid = 1'b0;
    // APB: access phase answered one cycle after it begins.
    access = psel && penable && !st_r.pready;
    is_chan = (paddr[11:7] == 5'h0) && (paddr[6:5] != 2'b00) && (paddr[6:5] != 2'b11);
    ch = paddr[6];
    mapped = 1'b1;
    rd = 32'h0;
    if (is_chan)
    begin
      unique case (paddr[4:2])
        angle_trim_pkg::CH_SCALE_IDX: rd = {17'h0, st_r.cfg[ch].scale};
        angle_trim_pkg::CH_SCALE_TC_IDX:
          rd = {5'h0, st_r.cfg[ch].lin_hot, 5'h0, st_r.cfg[ch].lin_cold};
        angle_trim_pkg::CH_SQUARE_TC_IDX:
          rd = {6'h0, st_r.cfg[ch].sq_hot, 6'h0, st_r.cfg[ch].sq_cold};
        angle_trim_pkg::CH_SHIFT_IDX: rd = {18'h0, st_r.cfg[ch].shift};
        angle_trim_pkg::CH_SHIFT_TC_IDX:
          rd = {4'h0, st_r.cfg[ch].shift_hot, 4'h0, st_r.cfg[ch].shift_cold};
        angle_trim_pkg::CH_DEADBAND_IDX: rd = {22'h0, st_r.cfg[ch].deadband};
        angle_trim_pkg::CH_READBACK_IDX: rd = {16'h0, st_r.hyst[ch].out};
        default: mapped = 1'b0;
      endcase
    end
    else
    begin
      unique case (paddr)
        angle_trim_pkg::CTRL_OFS: rd = {25'h0, st_r.ctrl};
        angle_trim_pkg::ZERO_OFS: rd = {17'h0, st_r.zero_shift};
        angle_trim_pkg::LIMIT_OFS:
          rd = {8'h0, st_r.wrap_point, st_r.limit_upper, st_r.limit_lower};
        angle_trim_pkg::GAIN_OFS: rd = {16'h0, st_r.scale_factor};
        angle_trim_pkg::STATUS_OFS: rd = {30'h0, st_r.sat, !st_r.ready};
        angle_trim_pkg::ANGLE_OFS: rd = {16'h0, st_r.angle};
        default: mapped = 1'b0;
      endcase
    end
    st_nxt.pready = access;
    st_nxt.pslverr = access && !mapped;
    st_nxt.prdata = (access && !pwrite) ? rd : 32'h0;
    if (access && pwrite && mapped)
    begin
      if (is_chan)
      begin
        unique case (paddr[4:2])
          angle_trim_pkg::CH_SCALE_IDX: st_nxt.cfg[ch].scale = pwdata[14:0];
          angle_trim_pkg::CH_SCALE_TC_IDX:
          begin
            st_nxt.cfg[ch].lin_cold = pwdata[10:0];
            st_nxt.cfg[ch].lin_hot = pwdata[angle_trim_pkg::HOT_POS +: 11];
          end
          angle_trim_pkg::CH_SQUARE_TC_IDX:
          begin
            st_nxt.cfg[ch].sq_cold = pwdata[9:0];
            st_nxt.cfg[ch].sq_hot = pwdata[angle_trim_pkg::HOT_POS +: 10];
          end
          angle_trim_pkg::CH_SHIFT_IDX: st_nxt.cfg[ch].shift = pwdata[13:0];
          angle_trim_pkg::CH_SHIFT_TC_IDX:
          begin
            st_nxt.cfg[ch].shift_cold = pwdata[11:0];
            st_nxt.cfg[ch].shift_hot = pwdata[angle_trim_pkg::HOT_POS +: 12];
          end
          angle_trim_pkg::CH_DEADBAND_IDX: st_nxt.cfg[ch].deadband = pwdata[9:0];
          default: st_nxt.cfg[ch] = st_r.cfg[ch];
        endcase
      end
      else
      begin
        unique case (paddr)
          angle_trim_pkg::CTRL_OFS: st_nxt.ctrl = pwdata[6:0];
          angle_trim_pkg::ZERO_OFS: st_nxt.zero_shift = pwdata[14:0];
          angle_trim_pkg::LIMIT_OFS:
          begin
            st_nxt.limit_lower = pwdata[7:0];
            st_nxt.limit_upper = pwdata[angle_trim_pkg::UPPER_POS +: 8];
            st_nxt.wrap_point = pwdata[angle_trim_pkg::WRAP_POS +: 8];
          end
          angle_trim_pkg::GAIN_OFS: st_nxt.scale_factor = pwdata[15:0];
          default: st_nxt.ctrl = st_r.ctrl;
        endcase
      end
    end

    // Arctangent argument choice and angle post-processing.
    sine = st_r.ctrl[angle_trim_pkg::SWAP_BIT] ? st_r.hyst[1].out : st_r.hyst[0].out;
    cosine = st_r.ctrl[angle_trim_pkg::SWAP_BIT] ? st_r.hyst[0].out : st_r.hyst[1].out;
    a1 = st_r.ctrl[angle_trim_pkg::DIR_INVERT_BIT] ? 16'h0 - st_r.cz : st_r.cz;
    a2 = a1 + {st_r.zero_shift, 1'b0};
    limit_hit = st_r.ctrl[angle_trim_pkg::LIMIT_ON_BIT]
      && ((a2 < {st_r.limit_lower, 8'h00}) || (a2 > {st_r.limit_upper, 8'h00}));
    prod = a2 * st_r.scale_factor;
    gained = prod[31:10];
    if (!st_r.ctrl[angle_trim_pkg::CLAMP_ON_BIT] || (gained[21:16] == 6'h0))
      a3 = gained[15:0];
    else if (a2 > {st_r.wrap_point, 8'h00})
      a3 = 16'h0000;
    else
      a3 = angle_trim_pkg::ANGLE_MAX;

    unique case (st_r.phase)
      angle_trim_pkg::PH_IDLE:
      begin
        if (sample_valid)
        begin
          st_nxt.smp = sample_in;
          st_nxt.ready = 1'b0;
          st_nxt.phase = angle_trim_pkg::PH_TRIM;
        end
      end
      angle_trim_pkg::PH_TRIM:
      begin
        st_nxt.hyst = hyst_upd;
        st_nxt.phase = angle_trim_pkg::PH_ANGLE;
      end
      angle_trim_pkg::PH_ANGLE:
      begin
        st_nxt.phase = angle_trim_pkg::PH_POST;
        st_nxt.iter = 4'h0;
        if (st_r.ctrl[angle_trim_pkg::SKIP_BIT])
          st_nxt.cz = sine + angle_trim_pkg::ANGLE_BIAS;
        else if ((sine == 16'sh0) && !cosine[15])
          st_nxt.cz = 16'h0000;
        else if (sine == 16'sh0)
          st_nxt.cz = angle_trim_pkg::ANGLE_HALF;
        else if (cosine == 16'sh0)
          st_nxt.cz = sine[15] ? angle_trim_pkg::ANGLE_3QUARTER
            : angle_trim_pkg::ANGLE_QUARTER;
        else
        begin
          st_nxt.phase = angle_trim_pkg::PH_CORDIC;
          st_nxt.cx = cosine[15] ? -20'(cosine) : 20'(cosine);
          st_nxt.cy = cosine[15] ? -20'(sine) : 20'(sine);
          st_nxt.cz = cosine[15] ? angle_trim_pkg::ANGLE_HALF : 16'h0000;
        end
      end
      angle_trim_pkg::PH_CORDIC:
      begin
        // Vectoring rotation drives the sine term to zero.
        if (!st_r.cy[19])
        begin
          st_nxt.cx = st_r.cx + (st_r.cy >>> st_r.iter);
          st_nxt.cy = st_r.cy - (st_r.cx >>> st_r.iter);
          st_nxt.cz = st_r.cz + angle_trim_pkg::atan_step(st_r.iter);
        end
        else
        begin
          st_nxt.cx = st_r.cx - (st_r.cy >>> st_r.iter);
          st_nxt.cy = st_r.cy + (st_r.cx >>> st_r.iter);
          st_nxt.cz = st_r.cz - angle_trim_pkg::atan_step(st_r.iter);
        end
        st_nxt.iter = st_r.iter + 4'h1;
        if (st_r.iter == angle_trim_pkg::CORDIC_LAST)
          st_nxt.phase = angle_trim_pkg::PH_POST;
      end
      angle_trim_pkg::PH_POST:
      begin
        st_nxt.angle = a3;
        st_nxt.sat = limit_hit;
        st_nxt.angle_valid = 1'b1;
        st_nxt.ready = 1'b1;
        st_nxt.phase = angle_trim_pkg::PH_IDLE;
      end
      default:
      begin
        st_nxt.ready = 1'b1;
        st_nxt.phase = angle_trim_pkg::PH_IDLE;
      end
    endcase
  end

  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
    begin
      st_r <= '0;
      st_r.phase <= angle_trim_pkg::PH_IDLE;
      st_r.ready <= 1'b1;
      st_r.ctrl <= angle_trim_pkg::CTRL_RST;
      st_r.scale_factor <= angle_trim_pkg::GAIN_RST;
      st_r.cfg[0].scale <= angle_trim_pkg::SCALE_RST;
      st_r.cfg[1].scale <= angle_trim_pkg::SCALE_RST;
    end
    else if (ce)
      st_r <= st_nxt;
  end

  assign prdata = st_r.prdata;
  assign pready = st_r.pready;
  assign pslverr = st_r.pslverr;
  assign sample_ready = st_r.ready;
  assign angle_out = st_r.angle;
  assign angle_valid = st_r.angle_valid;
  assign sat_flag = st_r.sat;

endmodule // angle_trim_signal_path

// ===== testbench/angle_trim_monitor.sv
`timescale 1ns/100ps
module angle_trim_monitor (
  input wire logic pclk,
  input wire logic presetn,
  input wire logic psel,
  input wire logic penable,
  input wire logic [31:0] prdata,
  input wire logic pready,
  input wire logic pslverr,
  input wire logic sample_valid,
  input wire logic sample_ready,
  input wire logic [15:0] angle_out,
  input wire logic angle_valid,
  input wire logic sat_flag
);
  default clocking cb @(posedge pclk);
  endclocking
  default disable iff (!presetn);
  sequence s_access;
    psel && penable && !pready;
  endsequence
  sequence s_take;
    sample_valid && sample_ready;
  endsequence
  a_apb_answer: assert property (s_access |=> pready)
    else $error("apb answer missing");
  a_ready_pulse: assert property (pready |=> !pready)
    else $error("pready longer than one cycle");
  a_rdata_idle: assert property (!pready |-> prdata == 32'h0)
    else $error("read data outside answer");
  a_err_ready: assert property (pslverr |-> pready)
    else $error("error without answer");
  a_take_busy: assert property (s_take |=> !sample_ready [*2])
    else $error("ready while sample in work");
  a_result_bound: assert property (s_take |-> ##[4:20] angle_valid)
    else $error("result missing");
  a_valid_pulse: assert property (angle_valid |=> !angle_valid)
    else $error("result pulse too long");
  a_ready_back: assert property (angle_valid |-> sample_ready)
    else $error("ready not back with result");
  a_angle_hold: assert property ($changed(angle_out) |-> angle_valid)
    else $error("angle changed without result");
  a_flag_hold: assert property ($changed(sat_flag) |-> angle_valid)
    else $error("flag changed without result");
endmodule // angle_trim_monitor

bind angle_trim_signal_path angle_trim_monitor mon (.pclk(pclk), .presetn(presetn),
  .psel(psel), .penable(penable), .prdata(prdata), .pready(pready), .pslverr(pslverr),
  .sample_valid(sample_valid), .sample_ready(sample_ready), .angle_out(angle_out),
  .angle_valid(angle_valid), .sat_flag(sat_flag));

// ===== testbench/sample_source.sv
`timescale 1ns/100ps
module sample_source (
  input wire logic pclk,
  input wire logic presetn,
  input wire logic send,
  input wire angle_trim_pkg::sample_t data,
  input wire logic sample_ready,
  output logic sample_valid,
  output angle_trim_pkg::sample_t sample_in
);
  // Holds an offer until taken, then shows the inverted word so stale data never matches.
  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
    begin
      sample_valid <= 1'b0;
      sample_in <= '0;
    end
    else if (sample_valid && sample_ready)
    begin
      sample_valid <= 1'b0;
      sample_in <= ~sample_in;
    end
    else if (send)
    begin
      sample_valid <= 1'b1;
      sample_in <= data;
    end
  end
endmodule // sample_source

// ===== testbench/tb_top.sv
`timescale 1ns/100ps
module tb_top;
  logic pclk = 1'b0;
  logic presetn = 1'b0;
  logic psel = 1'b0;
  logic penable = 1'b0;
  logic pwrite = 1'b0;
  logic [11:0] paddr = 12'h000;
  logic [31:0] pwdata = 32'h0;
  logic [31:0] prdata;
  logic pready, pslverr, sample_ready, angle_valid, sat_flag, sample_valid, er;
  logic [15:0] angle_out;
  logic send = 1'b0;
  angle_trim_pkg::sample_t data = '0;
  angle_trim_pkg::sample_t sample_in;
  int n_errors = 0;
  int num_checks = 0;
  int cyc = 0;
  logic [31:0] seed = 32'h8abe8714;
  logic [31:0] rd;
  logic [15:0] tol = 16'h0;
  logic [15:0] hin [7] = '{16'd0, 16'd50, 16'd200, 16'd150, 16'd90, 16'd60, 16'd120};
  logic [15:0] hout [7] = '{16'd0, 16'd50, 16'd200, 16'd200, 16'd90, 16'd60, 16'd60};

  angle_trim_signal_path uut (.pclk(pclk), .presetn(presetn), .ce(1'b1), .psel(psel),
    .penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata),
    .pready(pready), .pslverr(pslverr), .sample_valid(sample_valid),
    .sample_in(sample_in), .sample_ready(sample_ready), .angle_out(angle_out),
    .angle_valid(angle_valid), .sat_flag(sat_flag));
  sample_source src (.pclk(pclk), .presetn(presetn), .send(send), .data(data),
    .sample_ready(sample_ready), .sample_valid(sample_valid), .sample_in(sample_in));

  initial
  begin
    forever #2 pclk = ~pclk;
  end

  task automatic stop_test();
    $display("errors %0d checks %0d", n_errors, num_checks);
    if (n_errors == 0 && num_checks > 0)
      $display("verification passed");
    else
      $display("verification failed");
    $finish;
  endtask

  always @(posedge pclk)
  begin
    cyc <= cyc + 1;
    if (cyc == 30000)
    begin
      n_errors++;
      stop_test();
    end
  end

  function automatic logic [31:0] rnd();
    seed ^= seed << 13;
    seed ^= seed >> 17;
    seed ^= seed << 5;
    return seed;
  endfunction

  // Skip-mode angle at unity gain: channel choice, inversion, bias, direction, zero shift.
  function automatic logic [15:0] exp_skip(input logic [15:0] f, input logic [15:0] s,
    input logic [6:0] c, input logic [14:0] z);
    logic [15:0] v;
    v = c[3] ? s : f;
    if (c[3] ? c[1] : c[0])
      v = -v;
    v = v + 16'h8000;
    if (c[4])
      v = -v;
    return v + {z, 1'b0};
  endfunction

  task automatic check(input logic [31:0] got, input logic [31:0] exp, input string what);
    num_checks++;
    if (got !== exp)
    begin
      n_errors++;
      $display("MISMATCH %0t %s got %h exp %h", $time, what, got, exp);
    end
  endtask

  task automatic apb(input logic w, input logic [11:0] a, input logic [31:0] d);
    psel <= 1'b1;
    penable <= 1'b0;
    pwrite <= w;
    paddr <= a;
    pwdata <= d;
    @(posedge pclk);
    penable <= 1'b1;
    do
    begin
      @(posedge pclk);
    end
    while (pready !== 1'b1);
    rd = prdata;
    er = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
    @(posedge pclk);
  endtask

  task automatic wr(input logic [11:0] a, input logic [31:0] d);
    apb(1'b1, a, d);
  endtask

  task automatic rdchk(input logic [11:0] a, input logic [31:0] exp, input string what);
    apb(1'b0, a, 32'h0);
    check(rd, exp, what);
  endtask

  task automatic run(input logic [15:0] f, input logic [15:0] s, input logic [15:0] t,
    input logic [15:0] ea, input logic [15:0] eb);
    logic [15:0] dev;
    data <= {f, s, t};
    send <= 1'b1;
    @(posedge pclk);
    send <= 1'b0;
    do
    begin
      @(posedge pclk);
    end
    while (angle_valid !== 1'b1);
    // The iterative arctangent may sit a few codes off; tol is zero for exact cases.
    dev = angle_out - ea + tol;
    check({16'h0, (dev > {tol[14:0], 1'b0}) ? angle_out : ea}, {16'h0, ea}, "angle");
    rdchk(12'h038, {16'h0, eb}, "readback");
  endtask

  initial
  begin
    logic [31:0] r;
    logic [15:0] f, s;
    logic [6:0] c;
    repeat (16) @(posedge pclk);
    presetn <= 1'b1;
    @(posedge pclk);
    rdchk(angle_trim_pkg::CTRL_OFS, 32'h40, "ctrl reset");
    rdchk(12'h020, 32'h800, "scale reset");
    rdchk(angle_trim_pkg::GAIN_OFS, 32'h400, "gain reset");
    wr(12'h038, 32'h1234);
    rdchk(12'h038, 32'h0, "readback ro");
    apb(1'b0, 12'h01c, 32'h0);
    check({31'h0, er}, 32'h1, "unmapped err");
    check(rd, 32'h0, "unmapped data");
    run(16'h0, 16'd1000, 16'd200, 16'h0000, 16'h0);
    run(16'd1000, 16'h0, 16'd200, 16'h4000, 16'd1000);
    run(16'h0, 16'hfc18, 16'd200, 16'h8000, 16'h0);
    run(16'hfc18, 16'h0, 16'd200, 16'hc000, 16'hfc18);
    tol = 16'd16;
    run(16'h3e80, 16'h3e80, 16'd200, 16'h2000, 16'h3e80);
    run(16'h3e80, 16'hc180, 16'd200, 16'h6000, 16'h3e80);
    tol = 16'h0;
    repeat (12)
    begin
      r = rnd();
      c = 7'h44 | (r[6:0] & 7'h1b);
      {s, f} = rnd();
      if (f == 16'h8000)
        f = 16'h0;
      if (s == 16'h8000)
        s = 16'h0;
      wr(angle_trim_pkg::CTRL_OFS, {25'h0, c});
      wr(angle_trim_pkg::ZERO_OFS, {17'h0, r[30:16]});
      run(f, s, 16'd200, exp_skip(f, s, c, r[30:16]), c[0] ? -f : f);
    end
    wr(angle_trim_pkg::ZERO_OFS, 32'h0);
    wr(angle_trim_pkg::CTRL_OFS, 32'h04);
    wr(angle_trim_pkg::GAIN_OFS, 32'h800);
    run(16'h1234, 16'h0, 16'd200, 16'h2468, 16'h1234);
    wr(angle_trim_pkg::GAIN_OFS, 32'h0);
    run(16'h1234, 16'h0, 16'd200, 16'h0, 16'h1234);
    wr(angle_trim_pkg::CTRL_OFS, 32'h44);
    wr(angle_trim_pkg::GAIN_OFS, 32'h1000);
    wr(angle_trim_pkg::LIMIT_OFS, 32'h00a00000);
    run(16'h9000, 16'h0, 16'd200, 16'h4000, 16'h9000);
    run(16'he000, 16'h0, 16'd200, 16'hffff, 16'he000);
    run(16'h3000, 16'h0, 16'd200, 16'h0, 16'h3000);
    wr(angle_trim_pkg::CTRL_OFS, 32'h64);
    wr(angle_trim_pkg::GAIN_OFS, 32'h400);
    wr(angle_trim_pkg::LIMIT_OFS, 32'h8040);
    run(16'hb000, 16'h0, 16'd200, 16'h3000, 16'hb000);
    check({31'h0, sat_flag}, 32'h1, "low limit");
    run(16'hd000, 16'h0, 16'd200, 16'h5000, 16'hd000);
    check({31'h0, sat_flag}, 32'h0, "in range");
    run(16'h1000, 16'h0, 16'd200, 16'h9000, 16'h1000);
    check({31'h0, sat_flag}, 32'h1, "high limit");
    rdchk(angle_trim_pkg::STATUS_OFS, 32'h2, "status");
    rdchk(angle_trim_pkg::ANGLE_OFS, 32'h9000, "angle reg");
    wr(angle_trim_pkg::CTRL_OFS, 32'h44);
    wr(12'h020, 32'h1000);
    wr(12'h02c, 32'h5);
    run(16'd100, 16'h0, 16'd200, 16'h8000 + 16'd220, 16'd220);
    wr(12'h020, 32'h800);
    wr(12'h02c, 32'h0);
    wr(12'h024, 32'h02000100);
    run(16'd1600, 16'h0, 16'd456, 16'h8000 + 16'd1700, 16'd1700);
    run(16'd1600, 16'h0, 16'hffc8, 16'h8000 + 16'd1500, 16'd1500);
    wr(12'h024, 32'h0);
    wr(12'h030, 32'h00100008);
    run(16'd100, 16'h0, 16'd280, 16'h8000 + 16'd110, 16'd110);
    run(16'd100, 16'h0, 16'd120, 16'h8000 + 16'd90, 16'd90);
    presetn <= 1'b0;
    repeat (3) @(posedge pclk);
    presetn <= 1'b1;
    @(posedge pclk);
    wr(angle_trim_pkg::CTRL_OFS, 32'h44);
    wr(12'h034, 32'd100);
    for (int i = 0; i < 7; i++)
      run(hin[i], 16'h0, 16'd200, hout[i] + 16'h8000, hout[i]);
    stop_test();
  end
endmodule // tb_top
